//--- src/odc_pkg.sv
// constants and helpers shared by the output driver configuration block
package odc_pkg;
   localparam int unsigned NUM_OUT = 4;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   localparam int unsigned UA_W = 13;
   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_OUT_ZERO = 12'h0F0;
   localparam logic [ADDR_W-1:0] IDX_OUT_ONE = 12'h0F1;
   localparam logic [ADDR_W-1:0] IDX_OUT_TWO = 12'h0F2;
   localparam logic [ADDR_W-1:0] IDX_OUT_THREE = 12'h0F3;
   // field positions inside each control register
   localparam int unsigned FMT_BIT = 7;
   localparam int unsigned LEG_HI = 6;
   localparam int unsigned LEG_LO = 5;
   localparam int unsigned POL_HI = 4;
   localparam int unsigned POL_LO = 3;
   localparam int unsigned DRV_HI = 2;
   localparam int unsigned DRV_LO = 1;
   localparam int unsigned PD_BIT = 0;
   // differential, both legs on, non-inverting, 3.5 mA, powered up
   localparam logic [REG_W-1:0] CTRL_RESET = 8'h62;
   // drive current per code, in microamps
   localparam logic [UA_W-1:0] DRV_UA_0 = 13'h6D6;
   localparam logic [UA_W-1:0] DRV_UA_1 = 13'hDAC;
   localparam logic [UA_W-1:0] DRV_UA_2 = 13'h1482;
   localparam logic [UA_W-1:0] DRV_UA_3 = 13'h1B58;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
      byte_addr = {idx[ADDR_W-3:0], 2'h0};
   endfunction

   function automatic logic [UA_W-1:0] drive_ua(input logic [1:0] code);
      unique case (code)
         2'h0: drive_ua = DRV_UA_0;
         2'h1: drive_ua = DRV_UA_1;
         2'h2: drive_ua = DRV_UA_2;
         2'h3: drive_ua = DRV_UA_3;
      endcase
   endfunction
endpackage

//--- src/odc_out_drv.sv
// one clock output driver: decodes its control byte into leg levels and enables
`timescale 1ns/1ps
module odc_out_drv
   import odc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [odc_pkg::REG_W-1:0] ctrl,
   input wire logic clk_in,
   output logic leg_a,
   output logic leg_a_oe,
   output logic leg_b,
   output logic leg_b_oe,
   output logic diff_mode,
   output logic [odc_pkg::UA_W-1:0] drive_ua_val
);
   typedef struct packed {
      logic leg_a;
      logic leg_b;
      logic oe_a;
      logic oe_b;
      logic diff;
      logic [UA_W-1:0] ua;
   } odc_drv_state_t;

   odc_drv_state_t st_ff;
   odc_drv_state_t nxt_st;

   always_comb begin
      logic inv_a;
      logic inv_b;
      logic pd;
      inv_a = 1'b0;
      inv_b = 1'b0;
      pd = ctrl[PD_BIT];
      nxt_st = st_ff;
      nxt_st.diff = !ctrl[FMT_BIT];
      nxt_st.ua = drive_ua(ctrl[DRV_HI:DRV_LO]);
      if (!ctrl[FMT_BIT]) begin
         // upper polarity bit has no effect on a differential pair
         inv_a = ctrl[POL_LO];
         inv_b = !ctrl[POL_LO];
         nxt_st.oe_a = !pd;
         nxt_st.oe_b = !pd;
      end else begin
         inv_a = ctrl[POL_LO];
         inv_b = ctrl[POL_LO] ^ ctrl[POL_HI];
         // power-down also silences single-ended legs so no leg floats driven
         nxt_st.oe_a = ctrl[LEG_LO] && !pd;
         nxt_st.oe_b = ctrl[LEG_HI] && !pd;
      end
      nxt_st.leg_a = clk_in ^ inv_a;
      nxt_st.leg_b = clk_in ^ inv_b;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign leg_a = st_ff.leg_a;
   assign leg_b = st_ff.leg_b;
   assign leg_a_oe = st_ff.oe_a;
   assign leg_b_oe = st_ff.oe_b;
   assign diff_mode = st_ff.diff;
   assign drive_ua_val = st_ff.ua;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   diff_pol_a: assert property ($past(aresetn) && !$past(ctrl[FMT_BIT])
      |-> leg_a == ($past(clk_in) ^ $past(ctrl[POL_LO])) && leg_b == !leg_a)
      else $error("differential leg polarity wrong");
   cmos_pol_a: assert property ($past(aresetn) && $past(ctrl[FMT_BIT])
      |-> (leg_a ^ leg_b) == $past(ctrl[POL_HI]) && leg_a == ($past(clk_in) ^ $past(ctrl[POL_LO])))
      else $error("single-ended leg polarity wrong");
   drive_code_a: assert property ($past(aresetn) && $past(ctrl[DRV_HI:DRV_LO]) == 2'h3
      |-> drive_ua_val == DRV_UA_3)
      else $error("drive current does not follow code");
   power_up_a: assert property ($past(aresetn) && !$past(ctrl[FMT_BIT]) && !$past(ctrl[PD_BIT])
      |-> leg_a_oe && leg_b_oe)
      else $error("driver off while powered up");
   power_down_a: assert property ($past(aresetn) && $past(ctrl[PD_BIT])
      |-> !leg_a_oe && !leg_b_oe)
      else $error("driver active while powered down");
   format_sel_a: assert property ($past(aresetn) |-> diff_mode == !$past(ctrl[FMT_BIT]))
      else $error("format does not follow control");
   leg_en_a: assert property ($past(aresetn) && $past(ctrl[FMT_BIT]) && !$past(ctrl[PD_BIT])
      |-> {leg_b_oe, leg_a_oe} == $past(ctrl[LEG_HI:LEG_LO]))
      else $error("leg enables do not follow control");
endmodule

//--- src/odc_top.sv
// output driver configuration registers behind an AXI4-Lite slave
`timescale 1ns/1ps

// Summary of operation
// - polarity field sets leg inversion; differential ignores upper bit, single-ended uses both
// - drive field picks differential current 1.75, 3.5, 5.25 or 7.0 mA
// - power-down bit clear keeps the differential driver running normally
// - power-down bit set puts the output driver in high impedance
// - the next three registers decode identically, each for its own output
// - format bit clear selects differential, set selects single-ended outputs
// - in single-ended format the leg field enables none, A, B or both legs
module odc_top
   import odc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [odc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [odc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [odc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [odc_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [odc_pkg::NUM_OUT-1:0] src_clk,
   output logic [odc_pkg::NUM_OUT-1:0] clock_output_leg_a,
   output logic [odc_pkg::NUM_OUT-1:0] clock_output_leg_a_oe,
   output logic [odc_pkg::NUM_OUT-1:0] clock_output_leg_b,
   output logic [odc_pkg::NUM_OUT-1:0] clock_output_leg_b_oe,
   output logic [odc_pkg::NUM_OUT-1:0] clock_output_diff_mode,
   output logic [odc_pkg::NUM_OUT-1:0][odc_pkg::UA_W-1:0] clock_output_drive_ua
);
   typedef struct packed {
      logic [NUM_OUT-1:0][REG_W-1:0] ctrl;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [REG_W-1:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [REG_W-1:0] rdata;
   } odc_top_state_t;

   odc_top_state_t st_ff;
   odc_top_state_t nxt_st;

   // returns the output number for a byte address, or NUM_OUT when unmapped
   function automatic logic [2:0] decode(input logic [ADDR_W-1:0] addr);
      decode = 3'(NUM_OUT);
      if (addr == byte_addr(IDX_OUT_ZERO)) decode = 3'h0;
      if (addr == byte_addr(IDX_OUT_ONE)) decode = 3'h1;
      if (addr == byte_addr(IDX_OUT_TWO)) decode = 3'h2;
      if (addr == byte_addr(IDX_OUT_THREE)) decode = 3'h3;
   endfunction

   // a new address is refused while its response waits, which keeps one write in flight
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;

   always_comb begin
      logic [2:0] wsel;
      logic [2:0] rsel;
      wsel = decode(st_ff.awaddr);
      rsel = decode(s_axi_araddr);
      nxt_st = st_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata[REG_W-1:0];
         nxt_st.wstrb0 = s_axi_wstrb[0];
      end
      if (st_ff.aw_got && st_ff.w_got) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_SLVERR;
         if (wsel < 3'(NUM_OUT)) begin
            nxt_st.bresp = RESP_OKAY;
            // only the addressed output's byte changes
            if (st_ff.wstrb0) nxt_st.ctrl[wsel[1:0]] = st_ff.wdata;
         end
      end
      if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
      if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_SLVERR;
         nxt_st.rdata = '0;
         if (rsel < 3'(NUM_OUT)) begin
            nxt_st.rresp = RESP_OKAY;
            nxt_st.rdata = st_ff.ctrl[rsel[1:0]];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.ctrl <= {NUM_OUT{CTRL_RESET}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rdata = {{(DATA_W-REG_W){1'b0}}, st_ff.rdata};

   for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      // identical decoder per output, each fed only by its own register
      odc_out_drv u_drv (
         .aclk(aclk),
         .aresetn(aresetn),
         .ctrl(st_ff.ctrl[i]),
         .clk_in(src_clk[i]),
         .leg_a(clock_output_leg_a[i]),
         .leg_a_oe(clock_output_leg_a_oe[i]),
         .leg_b(clock_output_leg_b[i]),
         .leg_b_oe(clock_output_leg_b_oe[i]),
         .diff_mode(clock_output_diff_mode[i]),
         .drive_ua_val(clock_output_drive_ua[i])
      );
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   one_reg_a: assert property (st_ff.aw_got && st_ff.w_got && st_ff.wstrb0
      && decode(st_ff.awaddr) == 3'h1
      |=> st_ff.ctrl[1] == $past(st_ff.wdata) && $stable(st_ff.ctrl[0]) && $stable(st_ff.ctrl[2])
      && $stable(st_ff.ctrl[3]))
      else $error("write did not reach only its own register");
   // driver outputs lag the register and the source by exactly one edge
   other_pins_a: assert property ($past(aresetn) && $past(st_ff.ctrl[2]) == $past(st_ff.ctrl[3])
      && $past(src_clk[2]) == $past(src_clk[3])
      |-> clock_output_leg_a[2] == clock_output_leg_a[3]
      && clock_output_leg_b_oe[2] == clock_output_leg_b_oe[3])
      else $error("equal settings give unequal outputs");
   resp_after_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after acceptance");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   read_back_a: assert property (s_axi_arvalid && s_axi_arready && decode(s_axi_araddr) == 3'h0
      |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[7:0] == $past(st_ff.ctrl[0]))
      else $error("read data does not show register");
   unmapped_a: assert property (s_axi_arvalid && s_axi_arready && decode(s_axi_araddr) == 3'h4
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   power_up_pin_a: assert property ($past(aresetn) && !$past(st_ff.ctrl[0][PD_BIT])
      && !$past(st_ff.ctrl[0][FMT_BIT]) |-> clock_output_leg_a_oe[0])
      else $error("output zero off while powered up");

   write_cov: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
   read_cov: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
   cmos_cov: cover property (!clock_output_diff_mode[2] && clock_output_leg_b_oe[2] && !clock_output_leg_a_oe[2]);
   pd_cov: cover property (clock_output_diff_mode[1] && !clock_output_leg_a_oe[1]);
endmodule

//--- bench/tb_output_driver_config.sv
// self-checking testbench for the output driver configuration block
`timescale 1ns/1ps
module tb_output_driver_config;
   import odc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [DATA_W-1:0] rdata;
   // outputs two and three share a source level so equal settings must look alike
   logic [NUM_OUT-1:0] src = 4'hC;
   logic [3:0] wstrb = 4'hF;
   logic [NUM_OUT-1:0] la, la_oe, lb, lb_oe, dmode;
   logic [NUM_OUT-1:0][UA_W-1:0] ua;
   int miscompares = 0;
   int checks = 0;

   always #5 aclk = ~aclk;

   odc_top i_odc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .src_clk(src), .clock_output_leg_a(la), .clock_output_leg_a_oe(la_oe),
      .clock_output_leg_b(lb), .clock_output_leg_b_oe(lb_oe), .clock_output_diff_mode(dmode),
      .clock_output_drive_ua(ua));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // address and data are offered together; each is dropped at its own handshake
   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ap, wp, ha, hw;
      ap = 1'b1;
      wp = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ap || wp) begin
         @(negedge aclk);
         ha = ap && (awready === 1'b1);
         hw = wp && (wready === 1'b1);
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         ap = ap && !ha;
         wp = wp && !hw;
      end
      do begin
         @(negedge aclk);
      end while (bvalid !== 1'b1);
      check({30'h0, bresp}, {30'h0, er}, "bresp");
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
      end while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
      end while (rvalid !== 1'b1);
      check(rdata, {24'h0, ed}, "rdata");
      check({30'h0, rresp}, {30'h0, er}, "rresp");
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   task automatic check_out(input int i, input logic [7:0] v);
      logic fmt, ia, ib, ea, eb;
      // look away from the edge that launches the outputs
      @(negedge aclk);
      fmt = v[7];
      ia = v[3];
      ib = fmt ? v[3] ^ v[4] : !v[3];
      ea = !v[0] && (fmt ? v[5] : 1'b1);
      eb = !v[0] && (fmt ? v[6] : 1'b1);
      check({31'h0, dmode[i]}, {31'h0, !fmt}, "format");
      check({31'h0, la_oe[i]}, {31'h0, ea}, "leg a enable");
      check({31'h0, lb_oe[i]}, {31'h0, eb}, "leg b enable");
      if (ea) check({31'h0, la[i]}, {31'h0, src[i] ^ ia}, "leg a level");
      if (eb) check({31'h0, lb[i]}, {31'h0, src[i] ^ ib}, "leg b level");
      if (!fmt) check({19'h0, ua[i]}, 32'(1750 * (int'(v[2:1]) + 1)), "drive");
   endtask

   // legs follow the register one cycle after it commits, so settle two edges first
   task automatic set_out(input int i, input logic [7:0] v);
      axi_write(12'h3C0 + 12'(4 * i), v, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_out(i, v);
   endtask

   task automatic test_reset();
      for (int i = 0; i < 4; i++) begin
         axi_read(12'h3C0 + 12'(4 * i), 8'h62, RESP_OKAY);
         check_out(i, 8'h62);
      end
      $display("test reset done");
   endtask

   task automatic test_diff();
      for (int c = 0; c < 4; c++) set_out(0, 8'h60 | 8'(c << 1));
      for (int p = 0; p < 4; p++) set_out(1, 8'h62 | 8'(p << 3));
      set_out(1, 8'h63);
      $display("test differential done");
   endtask

   task automatic test_single_ended();
      for (int p = 0; p < 4; p++)
         for (int l = 0; l < 4; l++) set_out(2, 8'h82 | 8'(l << 5) | 8'(p << 3));
      set_out(2, 8'hE3);
      $display("test single ended done");
   endtask

   // distinct values per output catch crossed decode or address paths
   task automatic test_independent();
      logic [7:0] vals [4] = '{8'h05, 8'hA8, 8'hCE, 8'h7B};
      for (int i = 0; i < 4; i++) axi_write(12'h3C0 + 12'(4 * i), vals[i], RESP_OKAY);
      // byte strobe low: answered but the register must keep its value
      wstrb <= 4'h0;
      axi_write(12'h3C0, 8'hFF, RESP_OKAY);
      wstrb <= 4'hF;
      axi_write(12'h3D0, 8'hFF, RESP_SLVERR);
      axi_read(12'h3BC, 8'h00, RESP_SLVERR);
      src <= 4'h3;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
         axi_read(12'h3C0 + 12'(4 * i), vals[i], RESP_OKAY);
         check_out(i, vals[i]);
      end
      $display("test independent outputs done");
   endtask

   initial begin
      #50us;
      miscompares++;
      $display("wrong value at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset();
      test_diff();
      test_single_ended();
      test_independent();
      print_verdict();
   end
endmodule
